// [logic/hpa_pkg.sv]
// package of the headphone amplifier control port: register layout, codes, timing, carriers
// assumes a 10 MHz core clock and a bus master that keeps to standard two-wire signalling
package hpa_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // bus address and register rotation
  localparam logic [6:0] DEV_ADDR       = 7'h60;  // 1100000
  localparam logic [2:0] IDX_STATUS     = 3'h0;
  localparam logic [2:0] IDX_MODE       = 3'h1;
  localparam logic [2:0] IDX_VOLUME     = 3'h2;
  localparam logic [2:0] IDX_ZERO       = 3'h3;
  localparam logic [2:0] IDX_IDENT      = 3'h4;
  localparam logic [7:0] IDENT_DEFAULT  = 8'h5A;  // arbitrary value, no meaning

  ////////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int FS_LEFT_BIT    = 7;
  localparam int FS_RIGHT_BIT   = 6;
  localparam int FS_THERM_BIT   = 5;
  localparam int MODE_MSB       = 7;
  localparam int MODE_LSB       = 5;
  localparam int VOL_MUTE_L_BIT = 7;
  localparam int VOL_MUTE_R_BIT = 6;
  localparam int VOL_CODE_MSB   = 5;

  ////////////////////////////////////////////////////////////////////////////////
  // reset values and mode codes
  localparam logic [2:0] MODE_RESET    = 3'h0;
  localparam logic [7:0] VOLUME_RESET  = 8'h00;
  localparam logic [7:0] ZERO_VALUE    = 8'h00;
  localparam logic [2:0] MODE_RIGHT    = 3'h1;
  localparam logic [2:0] MODE_LEFT     = 3'h2;
  localparam logic [2:0] MODE_BOTH     = 3'h3;
  localparam logic [2:0] MODE_LINE_IN  = 3'h4;

  ////////////////////////////////////////////////////////////////////////////////
  // gain in half-dB steps
  localparam int GAIN_MUTE_HALF_DB = -160;
  localparam int GAIN_MIN_HALF_DB  = -120;
  localparam int GAIN_MID_HALF_DB  = -72;
  localparam int GAIN_FINE_HALF_DB = -33;
  localparam int GAIN_COARSE_END   = 9;
  localparam int GAIN_MID_END      = 22;

  ////////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_HZ       = 10_000_000;
  localparam int WAKE_TIME_MS = 12;
  localparam int WAKE_CYCLES  = WAKE_TIME_MS * (CLK_HZ / 1000);
  localparam int WAKE_CNT_W   = 24;

  ////////////////////////////////////////////////////////////////////////////////
  // protocol phases, one-hot
  typedef enum logic [6:0] {
    PH_IDLE      = 7'h01,
    PH_ADDR      = 7'h02,
    PH_ADDR_ACK  = 7'h04,
    PH_WRITE     = 7'h08,
    PH_WRITE_ACK = 7'h10,
    PH_READ      = 7'h20,
    PH_READ_ACK  = 7'h40
  } hpa_phase_t;

  // fault detector levels from the analog side
  typedef struct packed {
    logic left_short;
    logic right_short;
    logic thermal;
  } hpa_fault_t;

  // one amplifier channel as seen by the analog side
  typedef struct packed {
    logic              enable;
    logic              mute;
    logic signed [8:0] gain_half_db;
  } hpa_chan_t;

  // whole state of the control port
  typedef struct packed {
    hpa_phase_t            phase;
    logic                  scl_d;
    logic                  sda_d;
    logic [3:0]            bit_cnt;
    logic [7:0]            shift;
    logic [7:0]            tx;
    logic                  first_byte;
    logic [2:0]            rd_idx;
    logic                  sda_oe;
    logic [2:0]            mode;
    logic [7:0]            volume;
    logic                  left_short_flag;
    logic                  right_short_flag;
    logic [WAKE_CNT_W-1:0] wake_cnt;
    logic                  ready;
    logic                  supply_on;
    hpa_chan_t [1:0]       chan;
  } hpa_state_t;

endpackage

// [logic/hpa_sync.sv]
// two-stage synchroniser for levels that arrive from outside the core clock domain
// assumes each bit is an independent level; no multi-bit coherence is promised
module hpa_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage1;

  ////////////////////////////////////////////////////////////////////////////////
  // first stage only feeds the second, to keep metastability contained;
  // reset to each pin's idle level so no false edge follows reset
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      stage1   <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// [logic/hpa_i2c_ctrl.sv]
// two-wire slave control port and register file of the stereo headphone amplifier
// assumes scl, sda, the standby pin and fault levels are asynchronous; sda is open drain

////////////////////////////////////////////////////////////////////////////////
module hpa_i2c_ctrl #(
  parameter int         WAKE_CYCLES_P = hpa_pkg::WAKE_CYCLES,
  parameter logic [7:0] IDENT_P       = hpa_pkg::IDENT_DEFAULT
) (
  input  wire logic               clk_in,
  input  wire logic               rst_in,
  input  wire logic               master_standby_n_in,
  input  wire logic               scl_in,
  input  wire logic               sda_in,
  output logic                    sda_out,
  output logic                    sda_oe_out,
  input  wire hpa_pkg::hpa_fault_t fault_in,
  output logic [2:0]              mode_out,
  output logic                    supply_on_out,
  output logic                    wake_busy_out,
  output hpa_pkg::hpa_chan_t      left_chan_out,
  output hpa_pkg::hpa_chan_t      right_chan_out,
  output hpa_pkg::hpa_fault_t     fault_flags_out
);

  import hpa_pkg::*;

  hpa_state_t s;
  hpa_state_t next_s;
  hpa_state_t reset_s;
  logic [5:0] synced;
  logic       scl;
  logic       sda;
  logic       standby_n;
  hpa_fault_t flt;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_cond;
  logic       stop_cond;
  logic [7:0] status_byte;
  logic [7:0] rd_byte;

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisation
  hpa_sync #(
    .W       (6),
    .RST_VAL (6'h30)  // bus lines idle high, standby and detectors low
  ) u_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .async_in ({scl_in, sda_in, master_standby_n_in, fault_in}),
    .sync_out (synced)
  );

  assign scl       = synced[5];
  assign sda       = synced[4];
  assign standby_n = synced[3];
  assign flt       = synced[2:0];

  // bus events from the synced copies and their one-cycle history
  assign scl_rise   = scl & ~s.scl_d;
  assign scl_fall   = ~scl & s.scl_d;
  assign start_cond = scl & s.scl_d & s.sda_d & ~sda;
  assign stop_cond  = scl & s.scl_d & ~s.sda_d & sda;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic is_standby(input logic [2:0] m);
    return (m == MODE_RESET) || (m > MODE_LINE_IN);
  endfunction

  // volume code to gain in half-dB
  function automatic logic signed [8:0] gain_of(input logic [5:0] code);
    int c;
    int g;
    c = int'(code);
    if (c == 0) begin
      g = GAIN_MUTE_HALF_DB;
    end else if (c <= GAIN_COARSE_END) begin
      g = GAIN_MIN_HALF_DB + 6 * (c - 1);
    end else if (c <= GAIN_MID_END) begin
      g = GAIN_MID_HALF_DB + 3 * (c - GAIN_COARSE_END);
    end else begin
      g = GAIN_FINE_HALF_DB + (c - GAIN_MID_END);
    end
    return 9'(g);
  endfunction

  // status register view: short flags sticky, thermal follows its detector
  always_comb begin
    status_byte               = '0;
    status_byte[FS_LEFT_BIT]  = s.left_short_flag;
    status_byte[FS_RIGHT_BIT] = s.right_short_flag;
    status_byte[FS_THERM_BIT] = flt.thermal;
  end

  // read rotation source
  always_comb begin
    unique case (s.rd_idx)
      IDX_STATUS: rd_byte = status_byte;
      IDX_MODE:   rd_byte = {s.mode, 5'h00};
      IDX_VOLUME: rd_byte = s.volume;
      IDX_ZERO:   rd_byte = ZERO_VALUE;
      default:    rd_byte = IDENT_P;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // reset image: standby mode, mute volume, bus released
  always_comb begin
    reset_s            = '0;
    reset_s.phase      = PH_IDLE;
    reset_s.scl_d      = 1'b1;
    reset_s.sda_d      = 1'b1;
    reset_s.mode       = MODE_RESET;
    reset_s.volume     = VOLUME_RESET;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next-state logic: slave protocol, register writes, wake timer, channel drive
  always_comb begin
    next_s       = s;
    next_s.scl_d = scl;
    next_s.sda_d = sda;

    // short detectors set the flags; a set in the clear cycle wins below
    unique case (s.phase)
      PH_IDLE: begin
        next_s.sda_oe = 1'b0;
      end
      PH_ADDR: begin
        if (scl_rise) begin
          next_s.shift   = {s.shift[6:0], sda};
          next_s.bit_cnt = s.bit_cnt + 4'h1;
        end else if (scl_fall && s.bit_cnt == 4'h8) begin
          if (s.shift[7:1] == DEV_ADDR) begin
            next_s.phase  = PH_ADDR_ACK;
            next_s.sda_oe = 1'b1;
          end else begin
            next_s.phase = PH_IDLE;
          end
        end
      end
      PH_ADDR_ACK: begin
        if (scl_fall) begin
          next_s.bit_cnt = '0;
          if (s.shift[0]) begin
            next_s.phase  = PH_READ;
            next_s.tx     = rd_byte;
            next_s.rd_idx = IDX_MODE;
            next_s.sda_oe = ~rd_byte[7];
          end else begin
            next_s.phase            = PH_WRITE;
            next_s.first_byte       = 1'b1;
            next_s.sda_oe           = 1'b0;
            next_s.left_short_flag  = 1'b0;
            next_s.right_short_flag = 1'b0;
          end
        end
      end
      PH_WRITE: begin
        if (scl_rise) begin
          next_s.shift   = {s.shift[6:0], sda};
          next_s.bit_cnt = s.bit_cnt + 4'h1;
        end else if (scl_fall && s.bit_cnt == 4'h8) begin
          next_s.phase      = PH_WRITE_ACK;
          next_s.sda_oe     = 1'b1;
          next_s.first_byte = 1'b0;
          if (s.first_byte) begin
            next_s.mode = s.shift[MODE_MSB:MODE_LSB];
            if (is_standby(s.shift[MODE_MSB:MODE_LSB])) begin
              next_s.wake_cnt = '0;
              next_s.ready    = 1'b0;
            end else if (is_standby(s.mode)) begin
              next_s.wake_cnt = WAKE_CNT_W'(WAKE_CYCLES_P);
              next_s.ready    = 1'b0;
            end
          end else begin
            next_s.volume = s.shift;
          end
        end
      end
      PH_WRITE_ACK: begin
        if (scl_fall) begin
          next_s.phase   = PH_WRITE;
          next_s.sda_oe  = 1'b0;
          next_s.bit_cnt = '0;
        end
      end
      PH_READ: begin
        if (scl_fall) begin
          if (s.bit_cnt == 4'h7) begin
            next_s.phase  = PH_READ_ACK;
            next_s.sda_oe = 1'b0;
          end else begin
            next_s.tx      = {s.tx[6:0], 1'b0};
            next_s.sda_oe  = ~s.tx[6];
            next_s.bit_cnt = s.bit_cnt + 4'h1;
          end
        end
      end
      PH_READ_ACK: begin
        if (scl_rise && sda) begin
          next_s.phase = PH_IDLE;  // master ended the read with a nack
        end else if (scl_fall) begin
          next_s.phase   = PH_READ;
          next_s.tx      = rd_byte;
          next_s.sda_oe  = ~rd_byte[7];
          next_s.bit_cnt = '0;
          next_s.rd_idx  = (s.rd_idx == IDX_IDENT) ? IDX_STATUS : s.rd_idx + 3'h1;
        end
      end
    endcase

    // start and stop override any phase, including a repeated start
    if (start_cond) begin
      next_s.phase   = PH_ADDR;
      next_s.rd_idx  = IDX_STATUS;  // every read restarts at status
      next_s.bit_cnt = '0;
      next_s.sda_oe  = 1'b0;
    end else if (stop_cond) begin
      next_s.phase  = PH_IDLE;
      next_s.sda_oe = 1'b0;
    end

    // detector sets win over the write-transfer clear
    if (flt.left_short) begin
      next_s.left_short_flag = 1'b1;
    end
    if (flt.right_short) begin
      next_s.right_short_flag = 1'b1;
    end

    // de-pop timer: channel enables stay off until it runs out
    if (s.wake_cnt != '0) begin
      next_s.wake_cnt = s.wake_cnt - WAKE_CNT_W'(1);
      if (s.wake_cnt == WAKE_CNT_W'(1)) begin
        next_s.ready = 1'b1;
      end
    end

    // supply and channel drive from the next mode and volume
    next_s.supply_on = ~is_standby(next_s.mode) & ~flt.thermal;
    for (int i = 0; i < 2; i++) begin
      logic sel;
      logic mute_bit;
      sel      = (i == 0) ? (next_s.mode == MODE_LEFT || next_s.mode == MODE_BOTH)
                          : (next_s.mode == MODE_RIGHT || next_s.mode == MODE_BOTH);
      mute_bit = (i == 0) ? next_s.volume[VOL_MUTE_L_BIT] : next_s.volume[VOL_MUTE_R_BIT];
      next_s.chan[i].enable = sel & next_s.ready & ~flt.thermal
                            & ~((i == 0) ? next_s.left_short_flag : next_s.right_short_flag);
      next_s.chan[i].mute   = mute_bit | (next_s.volume[VOL_CODE_MSB:0] == 6'h00);
      next_s.chan[i].gain_half_db = next_s.chan[i].mute ? 9'(GAIN_MUTE_HALF_DB)
                                                        : gain_of(next_s.volume[VOL_CODE_MSB:0]);
    end

    // standby pin low returns everything to its initial state
    if (!standby_n) begin
      next_s       = reset_s;
      next_s.scl_d = scl;
      next_s.sda_d = sda;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s <= '{phase: PH_IDLE, scl_d: 1'b1, sda_d: 1'b1, mode: MODE_RESET, volume: VOLUME_RESET, default: '0};
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs from the state register, except the thermal flag, which is the synced detector; the slave only ever pulls sda low
  assign sda_out                     = 1'b0;
  assign sda_oe_out                  = s.sda_oe;
  assign mode_out                    = s.mode;
  assign supply_on_out               = s.supply_on;
  assign wake_busy_out               = (s.wake_cnt != '0);
  assign left_chan_out               = s.chan[0];
  assign right_chan_out              = s.chan[1];
  assign fault_flags_out.left_short  = s.left_short_flag;
  assign fault_flags_out.right_short = s.right_short_flag;
  assign fault_flags_out.thermal     = flt.thermal;

endmodule

// [test/hpa_i2c_ctrl_chk.sv]
// assertions on the amplifier control port pins
// assumes one core clock domain and the sim wake count
module hpa_i2c_ctrl_chk import hpa_pkg::*; #(
  parameter int WAKE_CYCLES_P = 50
) (
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic       master_standby_n_in,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_out,
  input wire hpa_fault_t fault_in,
  input wire logic [2:0] mode_out,
  input wire logic       supply_on_out,
  input wire logic       wake_busy_out,
  input wire hpa_chan_t  left_chan_out,
  input wire hpa_chan_t  right_chan_out,
  input wire hpa_fault_t fault_flags_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic [23:0] busy_cnt;
  // length of the current de-pop run
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) busy_cnt <= '0;
    else busy_cnt <= wake_busy_out ? busy_cnt + 24'h1 : '0;
  end
  ////////////////////////////////////////
  // pin low long enough to pass the synchroniser
  sequence s_pin_low; !master_standby_n_in [*5]; endsequence
  sequence s_det; (fault_in.left_short && master_standby_n_in) [*5]; endsequence
  property p_standby; s_pin_low |-> mode_out == MODE_RESET && !sda_oe_out; endproperty
  a_standby: assert property (p_standby) else $error("standby pin ignored");
  property p_sticky; s_det ##0 fault_flags_out.left_short |=> fault_flags_out.left_short; endproperty
  a_sticky: assert property (p_sticky) else $error("short flag lost");
  property p_clear; $fell(fault_flags_out.left_short) || $fell(fault_flags_out.right_short)
    |-> $fell(sda_oe_out) || !$past(master_standby_n_in, 3); endproperty
  a_clear: assert property (p_clear) else $error("short flag cleared outside a write");
  property p_oe_low; $changed(sda_oe_out) |-> !scl_in && !$past(scl_in, 2); endproperty
  a_oe_low: assert property (p_oe_low) else $error("data moved with clock high");
  property p_supply; mode_out == MODE_RESET || mode_out > MODE_LINE_IN |-> !supply_on_out; endproperty
  a_supply: assert property (p_supply) else $error("supply on in standby");
  property p_line_in; mode_out == MODE_LINE_IN |-> !left_chan_out.enable && !right_chan_out.enable; endproperty
  a_line_in: assert property (p_line_in) else $error("channel on in line-in");
  property p_chan;
    left_chan_out.enable || right_chan_out.enable |-> !wake_busy_out
      && (!left_chan_out.enable || mode_out == MODE_LEFT || mode_out == MODE_BOTH)
      && (!right_chan_out.enable || mode_out == MODE_RIGHT || mode_out == MODE_BOTH);
  endproperty
  a_chan: assert property (p_chan) else $error("channel on in wrong mode");
  property p_gain; left_chan_out.enable && !left_chan_out.mute |->
    left_chan_out.gain_half_db >= -120 && left_chan_out.gain_half_db <= 8; endproperty
  a_gain: assert property (p_gain) else $error("gain out of range");
  property p_wake; $fell(wake_busy_out) && mode_out != MODE_RESET && mode_out <= MODE_LINE_IN
    |-> busy_cnt == 24'(WAKE_CYCLES_P); endproperty
  a_wake: assert property (p_wake) else $error("de-pop run wrong length");
  property p_sda; sda_out == 1'b0; endproperty
  a_sda: assert property (p_sda) else $error("data pin driven high");
endmodule
bind hpa_i2c_ctrl hpa_i2c_ctrl_chk #(.WAKE_CYCLES_P(WAKE_CYCLES_P)) u_chk (
  .clk_in(clk_in), .rst_in(rst_in), .master_standby_n_in(master_standby_n_in),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
  .fault_in(fault_in), .mode_out(mode_out), .supply_on_out(supply_on_out),
  .wake_busy_out(wake_busy_out), .left_chan_out(left_chan_out),
  .right_chan_out(right_chan_out), .fault_flags_out(fault_flags_out));

// [test/hpa_host_model.sv]
// two-wire bus master standing in for the host controller
// assumes the bench resolves the open-drain data wire with a pull-up
module hpa_host_model (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out,
  output logic [7:0] rx_out,
  output logic      rx_stb_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // bus idle: both lines released, clock stands still
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
    rx_out = 8'h00;
    rx_stb_out = 1'b0;
  end
  ////////////////////////////////////////
  task automatic hold(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // hand one result to the bench's watcher
  task automatic note(input logic [7:0] v);
    rx_out = v;
    rx_stb_out = 1'b1;
    @(negedge clk_in);
    rx_stb_out = 1'b0;
  endtask
  // data changes only while the clock is low; 4-cycle phases give an 800 ns bus clock
  task automatic bit_io(input logic b, output logic r);
    sda_low_out = ~b;
    hold(2);
    scl_out = 1'b1;
    hold(2);
    r = sda_in;
    hold(2);
    scl_out = 1'b0;
    hold(2);
  endtask
  // start, or repeated start: data falls with the clock high
  task automatic start_c;
    sda_low_out = 1'b0;
    hold(4);
    scl_out = 1'b1;
    hold(4);
    sda_low_out = 1'b1;
    hold(4);
    scl_out = 1'b0;
    hold(4);
  endtask
  task automatic stop_c;
    sda_low_out = 1'b1;
    hold(4);
    scl_out = 1'b1;
    hold(4);
    sda_low_out = 1'b0;
    hold(8);
  endtask
  task automatic wr(input logic [7:0] d);
    logic [7:0] r;
    logic       a;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(1'b1, a);
    note({7'h00, a});
  endtask
  // last byte is refused by the master to end the read
  task automatic rd(input logic last);
    logic [7:0] r;
    logic       a;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, r[i]);
    note(r);
    bit_io(last, a);
  endtask
endmodule

// [test/headphone_amp_i2c_control_test.sv]
// self-checking bench of the amplifier control port
// assumes the host model as bus master and a pulled-up data wire
module headphone_amp_i2c_control_test import hpa_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int         WAKE  = 50;
  localparam logic [7:0] IDENT = 8'h3C; // arbitrary value
  logic       clk, rst, master_standby_n, scl, host_low, sda_oe, sda_o, sup, busy, stb;
  hpa_fault_t flt, flags;
  hpa_chan_t  lch, rch;
  logic [2:0] mode;
  logic [7:0] rx;
  logic [7:0] q[$];
  logic [5:0] codes[7] = '{6'd0, 6'd1, 6'd9, 6'd10, 6'd22, 6'd23, 6'd63};
  int         n_errors = 0;
  int         n_checks = 0;
  int         cyc = 0;
  // open drain: released wire goes high through the pull-up
  wire logic sda = ~(host_low | (sda_oe & ~sda_o));
  hpa_i2c_ctrl #(.WAKE_CYCLES_P(WAKE), .IDENT_P(IDENT)) u_dut (.clk_in(clk), .rst_in(rst),
    .master_standby_n_in(master_standby_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe),
    .fault_in(flt), .mode_out(mode), .supply_on_out(sup), .wake_busy_out(busy),
    .left_chan_out(lch), .right_chan_out(rch), .fault_flags_out(flags));
  hpa_host_model u_host (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_low_out(host_low),
    .rx_out(rx), .rx_stb_out(stb));
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // a hung bus ends the run as a failure
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      test_done();
    end
  end
  task automatic check(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // watcher: every ack or read byte is matched to the oldest queued expectation
  always @(posedge stb) begin
    if (q.size() == 0) check(16'(rx), 16'hFFFF);
    else check(16'(rx), 16'(q.pop_front()));
  end
  task automatic put(input logic [7:0] d, input logic nak);
    q.push_back({7'h00, nak});
    u_host.wr(d);
  endtask
  task automatic get(input logic [7:0] e, input logic last);
    q.push_back(e);
    u_host.rd(last);
  endtask
  // write transfer: mode byte, then nv volume bytes of which only the last is known
  task automatic wframe(input logic [7:0] m, input logic [7:0] v, input int nv);
    u_host.start_c();
    put(8'hC0, 1'b0);
    put(m, 1'b0);
    for (int k = 1; k < nv; k++) put(8'($urandom), 1'b0);
    if (nv > 0) put(v, 1'b0);
    u_host.stop_c();
    repeat (2) @(negedge clk);
  endtask
  function automatic logic [8:0] gain_of(input logic [5:0] c);
    int ci;
    int g;
    ci = int'(c);
    if (ci == 0) g = -160;
    else if (ci <= 9) g = -120 + 6 * (ci - 1);
    else if (ci <= 22) g = -72 + 3 * (ci - 9);
    else g = -33 + (ci - 22);
    return 9'(g);
  endfunction
  initial begin
    logic [7:0] v;
    logic [2:0] m;
    rst = 1'b1;
    master_standby_n = 1'b1;
    flt = '0;
    void'($urandom(27));
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    check(16'(mode), 16'h0000);
    check(16'(flags), 16'h0000);
    check(16'(sup), 16'h0000);
    foreach (codes[i]) if (i < 2) begin
      u_host.start_c();
      put(i == 0 ? 8'hC2 : 8'h40, 1'b1);
      u_host.stop_c();
    end
    check(16'(mode), 16'h0000);
    $display("reset and address test done");
    for (int i = 0; i < 8; i++) begin
      m = 3'(i);
      wframe({m, 5'h00}, 8'h00, 0);
      check(16'(mode), 16'(m));
      check(16'(sup), 16'(m != 3'h0 && m <= 3'h4));
      if (i == 1) check(16'(busy), 16'h0001);
      repeat (WAKE + 10) @(negedge clk);
      check(16'(lch.enable), 16'(m == 3'h2 || m == 3'h3));
      check(16'(rch.enable), 16'(m == 3'h1 || m == 3'h3));
    end
    $display("mode test done");
    for (int i = 0; i < 10; i++) begin
      v = (i < 7) ? {2'(i), codes[i]} : 8'($urandom);
      wframe(8'h60, v, 3);
      check(16'(lch.mute), 16'(v[7] | (v[5:0] == 6'h00)));
      check(16'(rch.mute), 16'(v[6] | (v[5:0] == 6'h00)));
      check({7'h00, lch.gain_half_db}, {7'h00, v[7] ? 9'h160 : gain_of(v[5:0])});
      check({7'h00, rch.gain_half_db}, {7'h00, v[6] ? 9'h160 : gain_of(v[5:0])});
    end
    $display("volume test done");
    flt.left_short = 1'b1;
    repeat (8) @(negedge clk);
    flt.left_short = 1'b0;
    repeat (4) @(negedge clk);
    u_host.start_c();
    put(8'hC1, 1'b0);
    get(8'h80, 1'b0);
    get(8'h60, 1'b0);
    get(v, 1'b0);
    get(8'h00, 1'b0);
    get(IDENT, 1'b0);
    get(8'h80, 1'b1);
    u_host.stop_c();
    check(16'(flags.left_short), 16'h0001);
    wframe(8'h60, v, 0);
    check(16'(flags.left_short), 16'h0000);
    $display("read test done");
    // right short with over-temperature, then a second read that must restart at status
    flt = 3'b011;
    repeat (6) @(negedge clk);
    check(16'(flags), 16'h0003);
    check(16'(sup), 16'h0000);
    check(16'(lch.enable), 16'h0000);
    flt = '0;
    repeat (6) @(negedge clk);
    check(16'(rch.enable), 16'h0000);
    u_host.start_c();
    put(8'hC1, 1'b0);
    get(8'h40, 1'b1);
    u_host.stop_c();
    wframe(8'h60, v, 0);
    check(16'({lch.enable, rch.enable}), 16'h0003);
    $display("fault test done");
    master_standby_n = 1'b0;
    repeat (6) @(negedge clk);
    check(16'(mode), 16'h0000);
    check(16'(lch.enable), 16'h0000);
    master_standby_n = 1'b1;
    $display("standby test done");
    test_done();
  end
endmodule
